// ---- logic/xch_pkg.sv ----
// shared widths, port indices, encodings and reset values of the bus exchanger
package xch_pkg;
   localparam int NUM_PORTS = 4;
   localparam int WORD_W = 9;
   localparam int CODE_W = 5;
   localparam int IDX_W = 2;

   typedef logic [WORD_W-1:0] xch_word_t;
   typedef logic [CODE_W-1:0] xch_code_t;
   typedef logic [IDX_W-1:0] xch_idx_t;

   // port indices, used both as receiver slot and as source select
   localparam xch_idx_t PORT_A1 = 2'h0;
   localparam xch_idx_t PORT_A2 = 2'h1;
   localparam xch_idx_t PORT_B1 = 2'h2;
   localparam xch_idx_t PORT_B2 = 2'h3;

   // route codes below this one drive nothing
   localparam xch_code_t CODE_OFF = 5'h00;
   localparam xch_code_t CODE_FIRST_LIVE = 5'h08;

   localparam xch_word_t WORD_RST = 9'h000;
   localparam logic [NUM_PORTS-1:0] OE_NONE = 4'h0;

   // two-entry buffer fill levels
   localparam logic [1:0] BUF_EMPTY = 2'h0;
   localparam logic [1:0] BUF_ONE = 2'h1;
   localparam logic [1:0] BUF_DEPTH = 2'h2;

   // decoded route: per receiver an enable and the source it takes from
   typedef struct packed {
      logic [NUM_PORTS-1:0] en;
      logic [NUM_PORTS-1:0][IDX_W-1:0] src;
   } xch_route_t;

   localparam xch_route_t ROUTE_NONE = '{en: 4'h0, src: 8'h00};

   // driver state; gray along dark -> live
   typedef enum logic {
      XCH_DARK = 1'b0,
      XCH_LIVE = 1'b1
   } xch_mode_t;
endpackage

// ---- logic/xch_stream_if.sv ----
// valid/ready word stream between the exchanger and its buffers
`timescale 1ns/1ns
`default_nettype none
interface xch_stream_if;
   logic valid;
   logic ready;
   logic [8:0] data;
   modport source (output valid, output data, input ready);
   modport sink (input valid, input data, output ready);
endinterface // xch_stream_if
`default_nettype wire

// ---- logic/xch_route_dec.sv ----
// route code to per-receiver enable and source select
`timescale 1ns/1ns
`default_nettype none
module xch_route_dec (
   input wire xch_pkg::xch_code_t code,
   output xch_pkg::xch_route_t route
);
   import xch_pkg::*;

   // adds one path tx -> rx to a decoded route
   function automatic xch_route_t link(xch_route_t r, xch_idx_t rx, xch_idx_t tx);
      xch_route_t t;
      t = r;
      t.en[rx] = 1'b1;
      t.src[rx] = tx;
      return t;
   endfunction

   // one table, so enables and selects can never disagree
   always_comb begin
      case (code)
         5'h08: route = link(link(ROUTE_NONE, PORT_A1, PORT_A2), PORT_B2, PORT_B1); // R6
         5'h09: route = link(ROUTE_NONE, PORT_A1, PORT_A2); // R6
         5'h0a: route = link(ROUTE_NONE, PORT_B1, PORT_B2); // R6
         5'h0b: route = link(link(ROUTE_NONE, PORT_A1, PORT_A2), PORT_B1, PORT_B2); // R6
         5'h0c: route = link(link(ROUTE_NONE, PORT_A2, PORT_A1), PORT_B2, PORT_B1); // R7
         5'h0d: route = link(ROUTE_NONE, PORT_A2, PORT_A1); // R7
         5'h0e: route = link(ROUTE_NONE, PORT_B2, PORT_B1); // R7
         5'h0f: route = link(link(ROUTE_NONE, PORT_A2, PORT_A1), PORT_B1, PORT_B2); // R7
         5'h10: route = link(link(ROUTE_NONE, PORT_B1, PORT_A1), PORT_A2, PORT_B2); // R8
         5'h11: route = link(ROUTE_NONE, PORT_B1, PORT_A1); // R8
         5'h12: route = link(ROUTE_NONE, PORT_B2, PORT_A2); // R8
         5'h13: route = link(link(ROUTE_NONE, PORT_B1, PORT_A1), PORT_B2, PORT_A2); // R8
         5'h14: route = link(link(ROUTE_NONE, PORT_A1, PORT_B1), PORT_B2, PORT_A2); // R9
         5'h15: route = link(ROUTE_NONE, PORT_A1, PORT_B1); // R9
         5'h16: route = link(ROUTE_NONE, PORT_A2, PORT_B2); // R9
         5'h17: route = link(link(ROUTE_NONE, PORT_A1, PORT_B1), PORT_A2, PORT_B2); // R9
         5'h18: route = link(link(ROUTE_NONE, PORT_A1, PORT_B2), PORT_B1, PORT_A2); // R10
         5'h19: route = link(ROUTE_NONE, PORT_A2, PORT_B1); // R10
         5'h1a: route = link(ROUTE_NONE, PORT_A1, PORT_B2); // R10
         5'h1b: route = link(link(ROUTE_NONE, PORT_A1, PORT_B2), PORT_A2, PORT_B1); // R10
         5'h1c: route = link(link(ROUTE_NONE, PORT_B2, PORT_A1), PORT_A2, PORT_B1); // R11
         5'h1d: route = link(ROUTE_NONE, PORT_B2, PORT_A1); // R11
         5'h1e: route = link(ROUTE_NONE, PORT_B1, PORT_A2); // R12
         5'h1f: route = link(link(ROUTE_NONE, PORT_B2, PORT_A1), PORT_B1, PORT_A2); // R12
         // off and unused codes both leave every driver off
         default: route = ROUTE_NONE; // R5 R16
      endcase
   end
endmodule // xch_route_dec
`default_nettype wire

// ---- logic/xch_skid_buf.sv ----
// two-entry word buffer with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module xch_skid_buf (
   input wire logic clk,
   input wire logic rst,
   input wire logic flush,
   xch_stream_if.sink fillSide,
   xch_stream_if.source drainSide
);
   import xch_pkg::*;

   typedef struct packed {
      logic [1:0][WORD_W-1:0] slot;
      logic [1:0] count;
      logic full;
   } xch_buf_state_t;

   xch_buf_state_t state_ff;
   xch_buf_state_t nxt_state;
   logic push;
   logic pop;

   // full is a flop so that the ready seen by the filler is clean
   assign fillSide.ready = ~state_ff.full;
   assign drainSide.valid = (state_ff.count != BUF_EMPTY);
   assign drainSide.data = state_ff.slot[0];
   assign push = fillSide.valid & ~state_ff.full;
   assign pop = drainSide.ready & (state_ff.count != BUF_EMPTY);

   // pop shifts first, push then lands behind what is left
   always_comb begin
      nxt_state = state_ff;
      if (pop) begin
         nxt_state.slot[0] = state_ff.slot[1];
         nxt_state.count = state_ff.count - BUF_ONE;
      end
      if (push) begin
         nxt_state.slot[nxt_state.count[0]] = fillSide.data;
         nxt_state.count = nxt_state.count + BUF_ONE;
      end
      if (flush) begin
         nxt_state.count = BUF_EMPTY;
      end
      nxt_state.full = (nxt_state.count == BUF_DEPTH);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // a pushed word into an empty buffer is the next word drained
   a_buf_first_out: assert property (@(posedge clk) disable iff (rst) // R13
      (push && state_ff.count == BUF_EMPTY && !pop && !flush)
      |=> (drainSide.valid && drainSide.data == $past(fillSide.data)))
      else $error("buffered word lost or altered");
endmodule // xch_skid_buf
`default_nettype wire

// ---- logic/xch_top.sv ----
// four-port nine-bit registered bus exchanger
// What this block does
// R1: load route from selector while load strobe low
// R2: strobe high keeps route, registers routed words
// R3: kill input disables all drivers immediately
// R4: leave kill only by clocked load
// R5: code zero turns every driver off
// R6: codes 08-0b route within the A and B pairs
// R7: codes 0c-0f route within pairs, other direction
// R8: codes 10-13 route A ports to B ports
// R9: codes 14-17 route B ports to A ports
// R10: codes 18-1b route crosswise between A and B
// R11: codes 1c-1d route a1 to b2 and more
// R12: codes 1e-1f route a2 to b1 and more
// R13: all nine bits travel together, registered
// R14: new routes switch cleanly on clock edges
// R15: unnamed receivers keep drivers off
// R16: unused codes behave like code zero
`timescale 1ns/1ns
`default_nettype none
module xch_top (
   input wire logic clk,
   input wire logic rst,
   input wire xch_pkg::xch_code_t routeSel,
   input wire logic routeLoad_n,
   input wire logic outputKill,
   input wire xch_pkg::xch_word_t portA1In,
   output logic [8:0] portA1Out,
   output logic portA1Oe,
   input wire xch_pkg::xch_word_t portA2In,
   output logic [8:0] portA2Out,
   output logic portA2Oe,
   input wire xch_pkg::xch_word_t portB1In,
   output logic [8:0] portB1Out,
   output logic portB1Oe,
   input wire xch_pkg::xch_word_t portB2In,
   output logic [8:0] portB2Out,
   output logic portB2Oe,
   input wire logic [3:0] portHold,
   output logic [3:0] portReady
);
   import xch_pkg::*;

   typedef struct packed {
      logic [NUM_PORTS-1:0][WORD_W-1:0] pinMeta;
      logic [NUM_PORTS-1:0][WORD_W-1:0] pinSync;
      xch_code_t selMeta;
      xch_code_t selSync;
      logic loadMeta_n;
      logic loadSync_n;
      logic killMeta;
      logic killSync;
      xch_code_t route;
      xch_mode_t mode;
      logic [NUM_PORTS-1:0] oe;
      logic [NUM_PORTS-1:0][WORD_W-1:0] dout;
   } xch_top_state_t;

   // strobe synchronisers idle high, so leaving reset is not taken as a load
   localparam xch_top_state_t TOP_RST = '{
      pinMeta: '0,
      pinSync: '0,
      selMeta: CODE_OFF,
      selSync: CODE_OFF,
      loadMeta_n: 1'b1,
      loadSync_n: 1'b1,
      killMeta: 1'b0,
      killSync: 1'b0,
      route: CODE_OFF,
      mode: XCH_DARK,
      oe: OE_NONE,
      dout: '0
   };

   xch_top_state_t state_ff;
   xch_top_state_t nxt_state;
   xch_route_t rxRoute;
   logic loadTaken;
   logic [NUM_PORTS-1:0] bufValid;
   logic [NUM_PORTS-1:0] bufReady;
   logic [NUM_PORTS-1:0] popWord;
   logic [NUM_PORTS-1:0][WORD_W-1:0] bufData;
   logic [NUM_PORTS-1:0] fillValid;

   // decode the held route code, never the raw selector pins
   xch_route_dec routeDec (
      .code(state_ff.route),
      .route(rxRoute)
   );

   // the route only changes on a load edge, so the enables can too
   assign loadTaken = ~state_ff.loadSync_n; // R1

   // one buffer per receiver; a load or kill flushes stale words
   for (genvar r = 0; r < NUM_PORTS; r++) begin : g_rx
      xch_stream_if fillIf ();
      xch_stream_if drainIf ();
      assign fillValid[r] = (state_ff.mode == XCH_LIVE) & rxRoute.en[r] // R15
         & state_ff.loadSync_n & ~state_ff.killSync;
      assign fillIf.valid = fillValid[r];
      assign fillIf.data = state_ff.pinSync[rxRoute.src[r]]; // R13
      assign drainIf.ready = ~portHold[r];
      assign bufValid[r] = drainIf.valid;
      assign bufData[r] = drainIf.data;
      assign bufReady[r] = fillIf.ready;
      assign popWord[r] = bufValid[r] & ~portHold[r];
      xch_skid_buf rxBuf (
         .clk(clk),
         .rst(rst),
         .flush(loadTaken | state_ff.killSync),
         .fillSide(fillIf.sink),
         .drainSide(drainIf.source)
      );
   end

   // pins pass two flops; route and mode update together, enables follow a cycle later
   always_comb begin
      nxt_state = state_ff;
      nxt_state.pinMeta[PORT_A1] = portA1In;
      nxt_state.pinMeta[PORT_A2] = portA2In;
      nxt_state.pinMeta[PORT_B1] = portB1In;
      nxt_state.pinMeta[PORT_B2] = portB2In;
      nxt_state.pinSync = state_ff.pinMeta;
      nxt_state.selMeta = routeSel;
      nxt_state.selSync = state_ff.selMeta;
      nxt_state.loadMeta_n = routeLoad_n;
      nxt_state.loadSync_n = state_ff.loadMeta_n;
      nxt_state.killMeta = outputKill;
      nxt_state.killSync = state_ff.killMeta;
      // strobe high leaves the route untouched
      if (loadTaken) begin
         nxt_state.route = state_ff.selSync; // R1 R2
      end
      // kill wins; only a load with kill low brings drivers back
      if (state_ff.killSync) begin
         nxt_state.mode = XCH_DARK; // R3
      end else if (loadTaken) begin
         nxt_state.mode = XCH_LIVE; // R4
      end
      // enables follow the decoded route a cycle later, on an edge
      if (state_ff.mode == XCH_LIVE && !state_ff.killSync) begin
         nxt_state.oe = rxRoute.en; // R14 R15 R5 R16
      end else begin
         nxt_state.oe = OE_NONE; // R3
      end
      for (int r = 0; r < NUM_PORTS; r++) begin
         if (popWord[r]) begin
            nxt_state.dout[r] = bufData[r]; // R2 R13
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_ff <= TOP_RST;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // data straight from flops; the kill gate is the one path past a clock
   assign portA1Out = state_ff.dout[PORT_A1];
   assign portA2Out = state_ff.dout[PORT_A2];
   assign portB1Out = state_ff.dout[PORT_B1];
   assign portB2Out = state_ff.dout[PORT_B2];
   assign portA1Oe = state_ff.oe[PORT_A1] & ~outputKill; // R3
   assign portA2Oe = state_ff.oe[PORT_A2] & ~outputKill; // R3
   assign portB1Oe = state_ff.oe[PORT_B1] & ~outputKill; // R3
   assign portB2Oe = state_ff.oe[PORT_B2] & ~outputKill; // R3
   assign portReady = bufReady;

   a_load_takes_sel: assert property (@(posedge clk) disable iff (rst) // R1
      loadTaken |=> (state_ff.route == $past(state_ff.selSync)))
      else $error("route not loaded from selector");

   a_route_kept_high: assert property (@(posedge clk) disable iff (rst) // R2
      state_ff.loadSync_n |=> $stable(state_ff.route))
      else $error("route changed without load strobe");

   a_kill_drivers_off: assert property (@(posedge clk) disable iff (rst) // R3
      outputKill |-> !(portA1Oe || portA2Oe || portB1Oe || portB2Oe))
      else $error("driver on while kill high");

   a_kill_goes_dark: assert property (@(posedge clk) disable iff (rst) // R3
      state_ff.killSync |=> (state_ff.mode == XCH_DARK && state_ff.oe == OE_NONE))
      else $error("kill did not darken the exchanger");

   a_dark_needs_load: assert property (@(posedge clk) disable iff (rst) // R4
      (state_ff.mode == XCH_DARK && !(loadTaken && !state_ff.killSync))
      |=> (state_ff.mode == XCH_DARK) ##1 (state_ff.oe == OE_NONE))
      else $error("left dark state without a clocked load");

   a_off_code_silent: assert property (@(posedge clk) disable iff (rst) // R5
      (state_ff.route < CODE_FIRST_LIVE) |=> (state_ff.oe == OE_NONE || $changed(state_ff.route)
      || $past(loadTaken)))
      else $error("driver enabled by off or unused code");

   a_unused_decodes: assert property (@(posedge clk) disable iff (rst) // R16
      (state_ff.route < CODE_FIRST_LIVE) |-> (rxRoute.en == OE_NONE))
      else $error("unused code decodes to a path");

   a_code09_path: assert property (@(posedge clk) disable iff (rst) // R6
      (state_ff.route == 5'h09) |-> (rxRoute.en == 4'h1 && rxRoute.src[PORT_A1] == PORT_A2))
      else $error("code 09 path wrong");

   a_code0f_path: assert property (@(posedge clk) disable iff (rst) // R7
      (state_ff.route == 5'h0f) |-> (rxRoute.en == 4'h6 && rxRoute.src[PORT_A2] == PORT_A1
      && rxRoute.src[PORT_B1] == PORT_B2))
      else $error("code 0f path wrong");

   a_code10_path: assert property (@(posedge clk) disable iff (rst) // R8
      (state_ff.route == 5'h10) |-> (rxRoute.en == 4'h6 && rxRoute.src[PORT_B1] == PORT_A1
      && rxRoute.src[PORT_A2] == PORT_B2))
      else $error("code 10 path wrong");

   a_code15_path: assert property (@(posedge clk) disable iff (rst) // R9
      (state_ff.route == 5'h15) |-> (rxRoute.en == 4'h1 && rxRoute.src[PORT_A1] == PORT_B1))
      else $error("code 15 path wrong");

   a_code19_path: assert property (@(posedge clk) disable iff (rst) // R10
      (state_ff.route == 5'h19) |-> (rxRoute.en == 4'h2 && rxRoute.src[PORT_A2] == PORT_B1))
      else $error("code 19 path wrong");

   a_code1d_path: assert property (@(posedge clk) disable iff (rst) // R11
      (state_ff.route == 5'h1d) |-> (rxRoute.en == 4'h8 && rxRoute.src[PORT_B2] == PORT_A1))
      else $error("code 1d path wrong");

   a_code1e_path: assert property (@(posedge clk) disable iff (rst) // R12
      (state_ff.route == 5'h1e) |-> (rxRoute.en == 4'h4 && rxRoute.src[PORT_B1] == PORT_A2))
      else $error("code 1e path wrong");

   a_code08_path: assert property (@(posedge clk) disable iff (rst) // R6
      (state_ff.route == 5'h08) |-> (rxRoute.en == 4'h9 && rxRoute.src[PORT_A1] == PORT_A2
      && rxRoute.src[PORT_B2] == PORT_B1))
      else $error("code 08 path wrong");

   a_code0a_path: assert property (@(posedge clk) disable iff (rst) // R6
      (state_ff.route == 5'h0a) |-> (rxRoute.en == 4'h4 && rxRoute.src[PORT_B1] == PORT_B2))
      else $error("code 0a path wrong");

   a_code0b_path: assert property (@(posedge clk) disable iff (rst) // R6
      (state_ff.route == 5'h0b) |-> (rxRoute.en == 4'h5 && rxRoute.src[PORT_A1] == PORT_A2
      && rxRoute.src[PORT_B1] == PORT_B2))
      else $error("code 0b path wrong");

   a_code0c_path: assert property (@(posedge clk) disable iff (rst) // R7
      (state_ff.route == 5'h0c) |-> (rxRoute.en == 4'ha && rxRoute.src[PORT_A2] == PORT_A1
      && rxRoute.src[PORT_B2] == PORT_B1))
      else $error("code 0c path wrong");

   a_code0d_path: assert property (@(posedge clk) disable iff (rst) // R7
      (state_ff.route == 5'h0d) |-> (rxRoute.en == 4'h2 && rxRoute.src[PORT_A2] == PORT_A1))
      else $error("code 0d path wrong");

   a_code0e_path: assert property (@(posedge clk) disable iff (rst) // R7
      (state_ff.route == 5'h0e) |-> (rxRoute.en == 4'h8 && rxRoute.src[PORT_B2] == PORT_B1))
      else $error("code 0e path wrong");

   a_code11_path: assert property (@(posedge clk) disable iff (rst) // R8
      (state_ff.route == 5'h11) |-> (rxRoute.en == 4'h4 && rxRoute.src[PORT_B1] == PORT_A1))
      else $error("code 11 path wrong");

   a_code12_path: assert property (@(posedge clk) disable iff (rst) // R8
      (state_ff.route == 5'h12) |-> (rxRoute.en == 4'h8 && rxRoute.src[PORT_B2] == PORT_A2))
      else $error("code 12 path wrong");

   a_code13_path: assert property (@(posedge clk) disable iff (rst) // R8
      (state_ff.route == 5'h13) |-> (rxRoute.en == 4'hc && rxRoute.src[PORT_B1] == PORT_A1
      && rxRoute.src[PORT_B2] == PORT_A2))
      else $error("code 13 path wrong");

   a_code14_path: assert property (@(posedge clk) disable iff (rst) // R9
      (state_ff.route == 5'h14) |-> (rxRoute.en == 4'h9 && rxRoute.src[PORT_A1] == PORT_B1
      && rxRoute.src[PORT_B2] == PORT_A2))
      else $error("code 14 path wrong");

   a_code16_path: assert property (@(posedge clk) disable iff (rst) // R9
      (state_ff.route == 5'h16) |-> (rxRoute.en == 4'h2 && rxRoute.src[PORT_A2] == PORT_B2))
      else $error("code 16 path wrong");

   a_code17_path: assert property (@(posedge clk) disable iff (rst) // R9
      (state_ff.route == 5'h17) |-> (rxRoute.en == 4'h3 && rxRoute.src[PORT_A1] == PORT_B1
      && rxRoute.src[PORT_A2] == PORT_B2))
      else $error("code 17 path wrong");

   a_code18_path: assert property (@(posedge clk) disable iff (rst) // R10
      (state_ff.route == 5'h18) |-> (rxRoute.en == 4'h5 && rxRoute.src[PORT_A1] == PORT_B2
      && rxRoute.src[PORT_B1] == PORT_A2))
      else $error("code 18 path wrong");

   a_code1a_path: assert property (@(posedge clk) disable iff (rst) // R10
      (state_ff.route == 5'h1a) |-> (rxRoute.en == 4'h1 && rxRoute.src[PORT_A1] == PORT_B2))
      else $error("code 1a path wrong");

   a_code1b_path: assert property (@(posedge clk) disable iff (rst) // R10
      (state_ff.route == 5'h1b) |-> (rxRoute.en == 4'h3 && rxRoute.src[PORT_A1] == PORT_B2
      && rxRoute.src[PORT_A2] == PORT_B1))
      else $error("code 1b path wrong");

   a_code1c_path: assert property (@(posedge clk) disable iff (rst) // R11
      (state_ff.route == 5'h1c) |-> (rxRoute.en == 4'ha && rxRoute.src[PORT_B2] == PORT_A1
      && rxRoute.src[PORT_A2] == PORT_B1))
      else $error("code 1c path wrong");

   a_code1f_path: assert property (@(posedge clk) disable iff (rst) // R12
      (state_ff.route == 5'h1f) |-> (rxRoute.en == 4'hc && rxRoute.src[PORT_B2] == PORT_A1
      && rxRoute.src[PORT_B1] == PORT_A2))
      else $error("code 1f path wrong");

   a_word_to_port: assert property (@(posedge clk) disable iff (rst) // R13
      popWord[PORT_A1] |=> (portA1Out == $past(bufData[PORT_A1])))
      else $error("popped word not driven on receiver");

   a_oe_clean_switch: assert property (@(posedge clk) disable iff (rst) // R14
      $changed(state_ff.oe) |-> ($past(state_ff.killSync) || $past(state_ff.mode != XCH_LIVE)
      || $past(loadTaken, 2) || $past(loadTaken)))
      else $error("driver enable moved without load or kill");

   a_idle_rx_off: assert property (@(posedge clk) disable iff (rst) // R15
      !rxRoute.en[PORT_B2] && $stable(state_ff.route) |=> !state_ff.oe[PORT_B2])
      else $error("unnamed receiver driving");
endmodule // xch_top
`default_nettype wire

// ---- verification/xch_bus_model.sv ----
// far-side bus model: drives words onto idle ports, stalls receivers on request
`timescale 1ns/1ns
`default_nettype none
module xch_bus_model (
   input wire logic [3:0][8:0] word,
   input wire logic [3:0] devOe,
   input wire logic [3:0][8:0] devOut,
   input wire logic [3:0] stallReq,
   output logic [3:0][8:0] busLevel,
   output logic [3:0] portHold
);
   // wire level: the device wins while it drives, else our whole nine-bit word
   always_comb begin
      for (int p = 0; p < 4; p++) begin
         busLevel[p] = devOe[p] ? devOut[p] : word[p];
      end
   end

   // a receiver that stalls simply holds its request level
   assign portHold = stallReq;
endmodule // xch_bus_model
`default_nettype wire

// ---- verification/xch_tb_top.sv ----
// self-checking bench for the four-port bus exchanger
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin totalChecks++; if ((got) !== (ex)) begin nFail++; \
   $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module xch_tb_top;
   import xch_pkg::*;
   // per code: src,dst,src,dst port digits; a source digit 4 means no path in that slot
   localparam logic [15:0] ROUTE_TBL [32] = '{
      16'h4444, 16'h4444, 16'h4444, 16'h4444, 16'h4444, 16'h4444, 16'h4444, 16'h4444,
      16'h1023, 16'h1044, 16'h3244, 16'h1032, 16'h0123, 16'h0144, 16'h2344, 16'h0132,
      16'h0231, 16'h0244, 16'h1344, 16'h0213, 16'h2013, 16'h2044, 16'h3144, 16'h2031,
      16'h3012, 16'h2144, 16'h3044, 16'h3021, 16'h0321, 16'h0344, 16'h1244, 16'h0312};

   logic clk, rst, routeLoad_n, outputKill, chkOn;
   xch_code_t routeSel;
   logic [3:0][8:0] word;
   wire logic [3:0][8:0] busIn, outV;
   logic [3:0][3:0][8:0] hist;
   logic [3:0] stallReq;
   wire logic [3:0] oeV, portHold, portReady;
   logic [31:0] rnd;
   int nFail, totalChecks;
   xch_route_t expR;

   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction

   // expected enables and sources worked out from the route table
   function automatic xch_route_t exp_route(input int code);
      xch_route_t r = ROUTE_NONE;
      logic [3:0] s;
      logic [3:0] d;
      for (int k = 0; k < 2; k++) begin
         s = ROUTE_TBL[code][15-8*k -: 4];
         d = ROUTE_TBL[code][11-8*k -: 4];
         if (s != 4'h4) begin
            r.en[d[1:0]] = 1'b1;
            r.src[d[1:0]] = s[1:0];
         end
      end
      return r;
   endfunction

   always #50 clk = ~clk;

   xch_bus_model xch_bus_model_i (.word(word), .devOe(oeV), .devOut(outV),
      .stallReq(stallReq), .busLevel(busIn), .portHold(portHold));

   xch_top xch_top_i (.clk(clk), .rst(rst), .routeSel(routeSel), .routeLoad_n(routeLoad_n),
      .outputKill(outputKill),
      .portA1In(busIn[0]), .portA1Out(outV[0]), .portA1Oe(oeV[0]),
      .portA2In(busIn[1]), .portA2Out(outV[1]), .portA2Oe(oeV[1]),
      .portB1In(busIn[2]), .portB1Out(outV[2]), .portB1Oe(oeV[2]),
      .portB2In(busIn[3]), .portB2Out(outV[3]), .portB2Oe(oeV[3]),
      .portHold(portHold), .portReady(portReady));

   // fresh random words on every port each cycle, just after the edge
   always @(posedge clk) begin
      #1;
      for (int p = 0; p < 4; p++) begin
         rnd = xs(rnd);
         word[p] = rnd[8:0];
      end
   end

   // bus levels as sampled; a routed word shows three edges later
   always @(posedge clk) hist <= {hist[2:0], busIn};

   // mid-cycle check of enables and routed words while a route stands
   always @(negedge clk) begin
      if (chkOn) begin
         for (int p = 0; p < 4; p++) begin
            `CHK("drive enable", expR.en[p], oeV[p])
            if (expR.en[p]) `CHK("routed word", hist[3][expR.src[p]], outV[p])
         end
      end
   end

   // one-cycle load, then the selector wanders while the load strobe is high
   task automatic load_route(input xch_code_t c);
      chkOn = 1'b0;
      @(posedge clk);
      #1 routeSel = c;
      routeLoad_n = 1'b0;
      @(posedge clk);
      #1 routeLoad_n = 1'b1;
      routeSel = ~c;
      expR = exp_route(int'(c));
      repeat (8) @(posedge clk);
      #1 chkOn = 1'b1;
      repeat (6) @(posedge clk);
      #1 chkOn = 1'b0;
   endtask

   task automatic final_report;
      if (nFail == 0 && totalChecks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      rst = 1'b1;
      routeLoad_n = 1'b1;
      outputKill = 1'b0;
      routeSel = CODE_OFF;
      word = '0;
      stallReq = 4'h0;
      chkOn = 1'b0;
      rnd = 32'h4740_2cf2;
      nFail = 0;
      totalChecks = 0;
      repeat (12) @(posedge clk);
      #1 rst = 1'b0;
      @(negedge clk);
      `CHK("reset enables", 4'h0, oeV)
      `CHK("reset ready", 4'hf, portReady)
      // every code once, undefined ones included
      for (int c = 0; c < 32; c++) begin
         load_route(c[4:0]);
      end
      // kill mid-stream drops every driver at once, no clock needed
      load_route(5'h13);
      @(posedge clk);
      #1 outputKill = 1'b1;
      #2 `CHK("kill enables", 4'h0, oeV)
      repeat (3) @(posedge clk);
      #1 outputKill = 1'b0;
      repeat (8) @(posedge clk);
      #5 `CHK("enables after kill", 4'h0, oeV)
      load_route(5'h13);
      // stall one receiver until its buffer refuses, then a load flushes it
      load_route(5'h09);
      @(posedge clk);
      #1 stallReq = 4'h1;
      repeat (6) @(posedge clk);
      #5 `CHK("full buffer ready", 1'b0, portReady[0])
      @(posedge clk);
      #1 stallReq = 4'h0;
      load_route(CODE_OFF);
      `CHK("flushed ready", 4'hf, portReady)
      final_report;
   end

   // hang guard, well past the roughly 610 cycles the sequence needs
   initial begin
      repeat (3000) @(posedge clk);
      nFail++;
      final_report;
   end
endmodule // xch_tb_top
`default_nettype wire
